// ---- design/vss_consts.svh ----
// Offsets, field positions, reset values and timing counts of the sag block.
// Assumes a 100 MHz system clock and 32-bit APB.
`ifndef VSS_CONSTS_SVH
`define VSS_CONSTS_SVH
`define VSS_CLK_HZ        100000000
`define VSS_TICK_MS       1
`define VSS_TICK_CYC      ((`VSS_CLK_HZ / 1000) * `VSS_TICK_MS)
`define VSS_DOUBLE_MS     1000
`define VSS_PROT_DLY_MS   500
`define VSS_CTRL_OFF      12'h000
`define VSS_LEVEL_OFF     12'h004
`define VSS_TIME0_OFF     12'h008
`define VSS_TIME1_OFF     12'h00c
`define VSS_STAT_OFF      12'h010
`define VSS_VOLT_OFF      12'h014
`define VSS_CTRL_EN       0
`define VSS_CTRL_RCL      1
`define VSS_CTRL_ARST     2
`define VSS_CTRL_EXT      3
`define VSS_CTRL_CLR      4
`define VSS_CTRL_START    5
`define VSS_CTRL_RST      32'h0000_0000
`define VSS_LEVEL_RST     32'h0000_0000
`define VSS_TIME0_RST     32'h0000_0000
`define VSS_TIME1_RST     32'h0000_0000
`endif

// ---- design/vss_pkg.sv ----
// Types of the voltage-sag supervision block.
// Assumes vss_consts.svh is included by the users of the package.
package vss_pkg;
    typedef enum logic [2:0] {
        VSS_IDLE,
        VSS_RIDE,
        VSS_DROPPED,
        VSS_WAIT_RST,
        VSS_ERROR
    } vss_state_t;

    typedef struct packed {
        logic        en;
        logic        rcl;
        logic        arst;
        logic        ext;
    } vss_cfg_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } vss_apb_req_t;
endpackage : vss_pkg

// ---- design/vss_sag_ctrl.sv ----
// Voltage-sag supervision and load-shedding sequencer with APB registers.
// Assumes a measured voltage word from a sibling block on clk and an
// asynchronous external low-voltage relay input.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "vss_consts.svh"
module vss_sag_ctrl (
    input  wire logic        clk,            // System clock 100 MHz
    input  wire logic        rst,            // Sync reset, high
    input  wire logic        psel,           // APB select
    input  wire logic        penable,        // APB enable
    input  wire logic        pwrite,         // APB direction
    input  wire logic [11:0] paddr,          // APB byte address
    input  wire logic [31:0] pwdata,         // APB write data
    output logic      [31:0] prdata,         // APB read data
    output logic             pready,         // APB ready
    output logic             pslverr,        // APB error
    input  wire logic [15:0] volt_meas,      // Internal voltage, same clock
    input  wire logic        ext_low_volt,   // External relay, async
    input  wire logic        test_pos,       // Test position, same clock
    output logic             contactor_on,   // Contactor drive
    output logic             sag_active,     // Sag in progress
    output logic             sag_dur_err,    // Sag duration error
    output logic             volt_prot_en,   // Voltage protections allowed
    output logic             load_prot_en    // Low-V, PF, low-P allowed
);
    localparam logic [16:0] TICK_CYC = 17'(`VSS_TICK_CYC);
    localparam logic [15:0] DOUBLE_MS = 16'(`VSS_DOUBLE_MS);

    function automatic logic [15:0] ms_inc(input logic [15:0] v);
        ms_inc = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction : ms_inc

    // Offsets that software may write; all else answers with an error
    function automatic logic wr_map(input logic [11:0] a);
        case (a)
            `VSS_CTRL_OFF,
            `VSS_LEVEL_OFF,
            `VSS_TIME0_OFF,
            `VSS_TIME1_OFF: wr_map = 1'b1;
            default:        wr_map = 1'b0;
        endcase
    endfunction : wr_map

    // Start-to-start spacing of two sags counts as a double sag
    function automatic logic in_window(input logic        seen,
                                       input logic [15:0] since);
        in_window = seen && (since < DOUBLE_MS);
    endfunction : in_window

    // Register file
    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic [31:0] level_ff;
    logic [31:0] nxt_level;
    logic [31:0] time0_ff;
    logic [31:0] nxt_time0;
    logic [31:0] time1_ff;
    logic [31:0] nxt_time1;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic        pready_ff;
    logic        nxt_pready;
    logic        pslverr_ff;
    logic        nxt_pslverr;
    logic        clr_req, start_req;
    logic        acc;
    logic        commit;
    logic        hit;

    vss_pkg::vss_cfg_t cfg;
    vss_pkg::vss_apb_req_t req;

    logic [15:0] start_lvl, rec_lvl, ride_ms, dur_ms, rdly_ms;

    // Sequencer state
    vss_pkg::vss_state_t st_ff, nxt_st;
    logic [16:0] div_ff, nxt_div;
    logic        tick;
    logic [15:0] sag_ms_ff, nxt_sag_ms;
    logic [15:0] rdly_cnt_ff, nxt_rdly_cnt;
    logic [15:0] since_ff, nxt_since;
    logic        seen_ff, nxt_seen;
    logic        sag_ff, nxt_sag;
    logic        err_ff, nxt_err;
    logic        con_ff, nxt_con;
    logic        vprot_ff, nxt_vprot;
    logic        lprot_ff, nxt_lprot;
    logic        ext_s1_ff, ext_s2_ff;
    logic        low_now;
    logic        sag_begin;
    logic        sag_end;

    always_comb begin
        req.psel    = psel;
        req.penable = penable;
        req.pwrite  = pwrite;
        req.paddr   = paddr;
        req.pwdata  = pwdata;
        cfg.en      = ctrl_ff[`VSS_CTRL_EN];
        cfg.rcl     = ctrl_ff[`VSS_CTRL_RCL];
        cfg.arst    = ctrl_ff[`VSS_CTRL_ARST];
        cfg.ext     = ctrl_ff[`VSS_CTRL_EXT];
        start_lvl   = level_ff[15:0];
        rec_lvl     = level_ff[31:16];
        ride_ms     = time0_ff[15:0];
        dur_ms      = time0_ff[31:16];
        rdly_ms     = time1_ff[15:0];
    end

    // One wait state: the answer is prepared in the first access cycle and
    // shown in the second; a write lands at the edge that completes it
    always_comb begin
        acc         = req.psel && req.penable && !pready_ff;
        commit      = req.psel && req.penable && req.pwrite && pready_ff
                      && wr_map(req.paddr);
        nxt_ctrl    = ctrl_ff;
        nxt_level   = level_ff;
        nxt_time0   = time0_ff;
        nxt_time1   = time1_ff;
        nxt_prdata  = prdata_ff;
        nxt_pready  = acc;
        nxt_pslverr = 1'b0;
        clr_req     = 1'b0;
        start_req   = 1'b0;
        hit         = 1'b1;
        if (acc) begin
            case (req.paddr)
                `VSS_CTRL_OFF:  nxt_prdata = {28'h0000000, ctrl_ff[3:0]};
                `VSS_LEVEL_OFF: nxt_prdata = level_ff;
                `VSS_TIME0_OFF: nxt_prdata = time0_ff;
                `VSS_TIME1_OFF: nxt_prdata = {16'h0000, time1_ff[15:0]};
                `VSS_STAT_OFF:  nxt_prdata = {24'h000000, 1'b0, st_ff,
                                              con_ff, err_ff, sag_ff, 1'b0};
                `VSS_VOLT_OFF:  nxt_prdata = {16'h0000, volt_meas};
                default: begin
                    hit        = 1'b0;
                    nxt_prdata = 32'h0000_0000;
                end
            endcase
            nxt_pslverr = !hit;
            if (req.pwrite) begin
                // Status and voltage are read only
                nxt_prdata  = 32'h0000_0000;
                nxt_pslverr = !wr_map(req.paddr);
            end
        end
        if (commit) begin
            case (req.paddr)
                `VSS_CTRL_OFF: begin
                    nxt_ctrl  = {28'h0000000, req.pwdata[3:0]};
                    clr_req   = req.pwdata[`VSS_CTRL_CLR];
                    start_req = req.pwdata[`VSS_CTRL_START];
                end
                `VSS_LEVEL_OFF: nxt_level = req.pwdata;
                `VSS_TIME0_OFF: nxt_time0 = req.pwdata;
                `VSS_TIME1_OFF: nxt_time1 = {16'h0000, req.pwdata[15:0]};
                default:        nxt_ctrl  = ctrl_ff;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff    <= `VSS_CTRL_RST;
            level_ff   <= `VSS_LEVEL_RST;
            time0_ff   <= `VSS_TIME0_RST;
            time1_ff   <= `VSS_TIME1_RST;
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            ctrl_ff    <= nxt_ctrl;
            level_ff   <= nxt_level;
            time0_ff   <= nxt_time0;
            time1_ff   <= nxt_time1;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Relay is not on clk; two stages before use
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
        end else begin
            ext_s1_ff <= ext_low_volt;
            ext_s2_ff <= ext_s1_ff;
        end
    end

    always_comb begin
        tick    = (div_ff == TICK_CYC - 17'h00001);
        nxt_div = tick ? 17'h00000 : div_ff + 17'h00001;
        // Hysteresis between the two levels applies to internal source only
        if (cfg.ext) begin
            low_now = ext_s2_ff;
        end else if (!sag_ff) begin
            low_now = (volt_meas < start_lvl);
        end else begin
            low_now = !(volt_meas >= rec_lvl);
        end
        sag_begin = cfg.en && !sag_ff && low_now;
        sag_end   = sag_ff && !low_now;
    end

    always_comb begin
        nxt_st       = st_ff;
        nxt_sag      = sag_ff;
        nxt_sag_ms   = sag_ms_ff;
        nxt_rdly_cnt = rdly_cnt_ff;
        nxt_since    = since_ff;
        nxt_seen     = seen_ff;
        nxt_con      = con_ff;
        // Sticky: a new error wins over a clear in the same cycle
        nxt_err      = err_ff && !clr_req;
        if (tick && in_window(seen_ff, since_ff)) begin
            nxt_since = ms_inc(since_ff);
        end
        if (start_req) begin
            nxt_con = 1'b1;
        end
        if (!cfg.en) begin
            nxt_st  = vss_pkg::VSS_IDLE;
            nxt_sag = 1'b0;
        end else begin
            if (sag_begin) begin
                nxt_sag    = 1'b1;
                nxt_sag_ms = 16'h0000;
                nxt_seen   = 1'b1;
                nxt_since  = 16'h0000;
            end else if (sag_end) begin
                nxt_sag = 1'b0;
            end else if (sag_ff && tick) begin
                nxt_sag_ms = ms_inc(sag_ms_ff);
            end
            case (st_ff)
                vss_pkg::VSS_IDLE: begin
                    if (sag_begin) begin
                        if (cfg.rcl && in_window(seen_ff, since_ff)) begin
                            nxt_con = 1'b0;
                            nxt_st  = vss_pkg::VSS_DROPPED;
                        end else begin
                            nxt_st = vss_pkg::VSS_RIDE;
                        end
                    end
                end
                vss_pkg::VSS_RIDE: begin
                    if (sag_end) begin
                        nxt_st = vss_pkg::VSS_IDLE;
                    end else if (sag_ms_ff >= ride_ms) begin
                        nxt_con = 1'b0;
                        nxt_st  = vss_pkg::VSS_DROPPED;
                    end
                end
                vss_pkg::VSS_DROPPED: begin
                    if (sag_ms_ff >= dur_ms && !sag_end) begin
                        nxt_err = 1'b1;
                        nxt_st  = vss_pkg::VSS_ERROR;
                    end else if (sag_end || !sag_ff) begin
                        nxt_rdly_cnt = 16'h0000;
                        nxt_st = cfg.arst ? vss_pkg::VSS_WAIT_RST
                                          : vss_pkg::VSS_IDLE;
                    end
                end
                vss_pkg::VSS_WAIT_RST: begin
                    if (sag_begin) begin
                        nxt_st = vss_pkg::VSS_DROPPED;
                    end else if (rdly_cnt_ff >= rdly_ms) begin
                        nxt_con = 1'b1;
                        nxt_st  = vss_pkg::VSS_IDLE;
                    end else if (tick) begin
                        nxt_rdly_cnt = ms_inc(rdly_cnt_ff);
                    end
                end
                vss_pkg::VSS_ERROR: begin
                    if (!sag_ff) begin
                        nxt_st = vss_pkg::VSS_IDLE;
                    end
                end
                default: nxt_st = vss_pkg::VSS_IDLE;
            endcase
        end
        nxt_vprot = !test_pos && !nxt_sag;
        nxt_lprot = !test_pos && !nxt_sag;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff       <= vss_pkg::VSS_IDLE;
            div_ff      <= 17'h00000;
            sag_ff      <= 1'b0;
            sag_ms_ff   <= 16'h0000;
            rdly_cnt_ff <= 16'h0000;
            since_ff    <= 16'h0000;
            seen_ff     <= 1'b0;
            err_ff      <= 1'b0;
            con_ff      <= 1'b0;
            vprot_ff    <= 1'b0;
            lprot_ff    <= 1'b0;
        end else begin
            st_ff       <= nxt_st;
            div_ff      <= nxt_div;
            sag_ff      <= nxt_sag;
            sag_ms_ff   <= nxt_sag_ms;
            rdly_cnt_ff <= nxt_rdly_cnt;
            since_ff    <= nxt_since;
            seen_ff     <= nxt_seen;
            err_ff      <= nxt_err;
            con_ff      <= nxt_con;
            vprot_ff    <= nxt_vprot;
            lprot_ff    <= nxt_lprot;
        end
    end

    assign prdata       = prdata_ff;
    assign pready       = pready_ff;
    assign pslverr      = pslverr_ff;
    assign contactor_on = con_ff;
    assign sag_active   = sag_ff;
    assign sag_dur_err  = err_ff;
    assign volt_prot_en = vprot_ff;
    assign load_prot_en = lprot_ff;
endmodule : vss_sag_ctrl
`default_nettype wire

// ---- bench/vss_sag_ctrl_props.sv ----
// Port-level checker of the sag sequencer, bound to every instance.
// Assumes a single clock domain and the one-wait-state APB answer.
`timescale 1ns/1ps
`default_nettype none
`include "vss_consts.svh"
module vss_sag_ctrl_props (
    input wire logic        clk,          // Clock
    input wire logic        rst,          // Sync reset
    input wire logic        psel,         // APB select
    input wire logic        penable,      // APB enable
    input wire logic        pwrite,       // APB direction
    input wire logic [11:0] paddr,        // APB address
    input wire logic [31:0] pwdata,       // APB write data
    input wire logic [31:0] prdata,       // APB read data
    input wire logic        pready,       // APB ready
    input wire logic        pslverr,      // APB error
    input wire logic        test_pos,     // Test position
    input wire logic        contactor_on, // Contactor drive
    input wire logic        sag_active,   // Sag flag
    input wire logic        sag_dur_err,  // Duration error
    input wire logic        volt_prot_en, // Voltage protections
    input wire logic        load_prot_en  // Load protections
);
    // Clear request as the bus presents it in both access cycles
    wire clr_req = psel && penable && pwrite && paddr == `VSS_CTRL_OFF
                   && pwdata[`VSS_CTRL_CLR];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_load_mask;
        sag_active |-> !load_prot_en;
    endproperty
    a_load_mask: assert property (p_load_mask)
        else $error("load prot on in sag");
    property p_test_mask;
        test_pos |=> !volt_prot_en;
    endproperty
    a_test_mask: assert property (p_test_mask)
        else $error("volt prot in test");
    property p_sag_mask;
        sag_active |-> !volt_prot_en;
    endproperty
    a_sag_mask: assert property (p_sag_mask)
        else $error("volt prot in sag");
    property p_rdy_time;
        $rose(penable) && psel |=> pready;
    endproperty
    a_rdy_time: assert property (p_rdy_time)
        else $error("pready late");
    property p_rdy_pulse;
        pready |=> !pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("pready too long");
    property p_err_data;
        pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    a_err_data: assert property (p_err_data)
        else $error("bad error answer");
    property p_err_clr;
        $fell(sag_dur_err) |-> $past(clr_req) || $past(clr_req, 2);
    endproperty
    a_err_clr: assert property (p_err_clr)
        else $error("error not sticky");
    property p_err_sag;
        $rose(sag_dur_err) |-> sag_active || $past(sag_active);
    endproperty
    a_err_sag: assert property (p_err_sag)
        else $error("error without sag");
    property p_drop;
        $fell(contactor_on) |-> ($past(sag_active) or ##[0:1] sag_active);
    endproperty
    a_drop: assert property (p_drop)
        else $error("drop outside sag");
endmodule : vss_sag_ctrl_props
bind vss_sag_ctrl vss_sag_ctrl_props vss_sag_ctrl_props_i (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .test_pos(test_pos), .contactor_on(contactor_on), .sag_active(sag_active),
    .sag_dur_err(sag_dur_err), .volt_prot_en(volt_prot_en),
    .load_prot_en(load_prot_en));
`default_nettype wire

// ---- bench/vss_volt_src.sv ----
// Model of the measurement module and the external low-voltage relay.
// Assumes the bench sets the wanted voltage and relay state.
`timescale 1ns/1ps
`default_nettype none
module vss_volt_src (
    input  wire logic        clk,          // Clock
    input  wire logic [15:0] set_volt,     // Wanted voltage
    input  wire logic        set_low,      // Wanted relay state
    output logic      [15:0] volt_meas,    // Measured voltage
    output logic             ext_low_volt  // Relay contact
);
    always_ff @(posedge clk) volt_meas <= set_volt;
    // Relay is not clocked: block must synchronise it
    assign ext_low_volt = set_low;
endmodule : vss_volt_src
`default_nettype wire

// ---- bench/vss_sag_ctrl_tb.sv ----
// Self-checking bench of the sag sequencer: APB table, then sag cases.
// Assumes no fixed APB wait-state count; the apb task waits for pready.
`timescale 1ns/1ps
`default_nettype none
`include "vss_consts.svh"
module vss_sag_ctrl_tb;
    typedef struct {logic [11:0] a; logic [31:0] d; logic we;
                    logic [31:0] q; logic re;} vss_row_t;
    logic clk = 1'b0, rst, psel, penable, pwrite, test_pos, set_low;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] set_volt, volt_meas;
    logic pready, pslverr, ext_low_volt, e;
    logic contactor_on, sag_active, sag_dur_err, volt_prot_en, load_prot_en;
    int bad_count = 0, checks = 0;
    vss_row_t rows [6] = '{
        '{`VSS_LEVEL_OFF, 32'h00c8_0064, 1'b0, 32'h00c8_0064, 1'b0},
        '{`VSS_TIME0_OFF, 32'hffff_0000, 1'b0, 32'hffff_0000, 1'b0},
        '{`VSS_TIME1_OFF, 32'h0000_0000, 1'b0, 32'h0000_0000, 1'b0},
        '{`VSS_STAT_OFF,  32'h0000_00ff, 1'b1, 32'h0000_0000, 1'b0},
        '{`VSS_VOLT_OFF,  32'h0000_0000, 1'b1, 32'h0000_0032, 1'b0},
        '{12'h018,        32'h1234_5678, 1'b1, 32'h0000_0000, 1'b1}};
    always #5 clk = ~clk;
    vss_volt_src vss_volt_src_i (.clk(clk), .set_volt(set_volt),
        .set_low(set_low), .volt_meas(volt_meas), .ext_low_volt(ext_low_volt));
    vss_sag_ctrl vss_sag_ctrl_i (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .volt_meas(volt_meas), .ext_low_volt(ext_low_volt),
        .test_pos(test_pos), .contactor_on(contactor_on),
        .sag_active(sag_active), .sag_dur_err(sag_dur_err),
        .volt_prot_en(volt_prot_en), .load_prot_en(load_prot_en));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No wait-state count assumed; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    function automatic logic sig(input int s);
        case (s)
            0: return contactor_on;
            1: return sag_active;
            default: return sag_dur_err;
        endcase
    endfunction : sig
    task automatic wait_sig(input int s, input logic v, input int lim);
        int n;
        n = 0;
        while (sig(s) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk(sig(s), v);
    endtask : wait_sig
    task automatic summarize();
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize();
    end
    initial begin
        {rst, psel, penable, pwrite, test_pos, set_low} = 6'b100000;
        paddr = 12'h000;
        pwdata = 32'h0;
        set_volt = 16'h0032;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({contactor_on, sag_active, sag_dur_err}, 3'h0);
        test_pos <= 1'b1;
        repeat (4) @(posedge clk);
        chk(volt_prot_en, 1'b0);
        test_pos <= 1'b0;
        repeat (4) @(posedge clk);
        chk(volt_prot_en, 1'b1);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            chk(e, rows[i].we);
            apb(1'b0, rows[i].a, 32'h0);
            chk(q, rows[i].q);
            chk(e, rows[i].re);
        end
        chk(sag_active, 1'b0);
        set_volt <= 16'h00fa;
        apb(1'b1, `VSS_CTRL_OFF, 32'h0000_0025);
        apb(1'b0, `VSS_CTRL_OFF, 32'h0);
        chk(q, 32'h0000_0005);
        wait_sig(0, 1'b1, 20);
        set_volt <= 16'h0032;
        wait_sig(1, 1'b1, 20);
        chk(load_prot_en, 1'b0);
        repeat (3) @(posedge clk);
        chk({load_prot_en, volt_prot_en}, 2'b00);
        wait_sig(0, 1'b0, 20);
        set_volt <= 16'h0096;
        repeat (20) @(posedge clk);
        chk(sag_active, 1'b1);
        apb(1'b0, `VSS_STAT_OFF, 32'h0);
        chk(q, 32'h0000_0022);
        set_volt <= 16'h00c8;
        wait_sig(1, 1'b0, 20);
        wait_sig(0, 1'b1, 20);
        repeat (3) @(posedge clk);
        chk(load_prot_en, 1'b1);
        apb(1'b1, `VSS_TIME0_OFF, 32'h0000_0000);
        apb(1'b1, `VSS_CTRL_OFF, 32'h0000_000d);
        set_volt <= 16'h0032;
        repeat (20) @(posedge clk);
        chk(sag_active, 1'b0);
        set_low <= 1'b1;
        wait_sig(1, 1'b1, 20);
        wait_sig(2, 1'b1, 20);
        set_low <= 1'b0;
        set_volt <= 16'h00fa;
        wait_sig(1, 1'b0, 20);
        apb(1'b1, `VSS_CTRL_OFF, 32'h0000_001d);
        repeat (20) @(posedge clk);
        chk({sag_dur_err, contactor_on}, 2'b00);
        apb(1'b1, `VSS_TIME0_OFF, 32'hffff_ffff);
        apb(1'b1, `VSS_CTRL_OFF, 32'h0000_0025);
        wait_sig(0, 1'b1, 20);
        set_volt <= 16'h0032;
        wait_sig(1, 1'b1, 20);
        set_volt <= 16'h00fa;
        wait_sig(1, 1'b0, 20);
        chk(contactor_on, 1'b1);
        // Lockout armed only now, so the next sag is the second one
        apb(1'b1, `VSS_CTRL_OFF, 32'h0000_0007);
        set_volt <= 16'h0032;
        wait_sig(0, 1'b0, 6);
        set_volt <= 16'h00fa;
        wait_sig(0, 1'b1, 30);
        summarize();
    end
endmodule : vss_sag_ctrl_tb
`default_nettype wire
